// file: design/csq_pkg.sv
// Constants, types and register map of the compressor motor sequencer.
// Assumes one 100 MHz clock and a plain register port with 16-bit data.
package csq_pkg;
  localparam int DW = 16;
  localparam int CLK_MHZ = 100;
  localparam int MS_NS = 1000000;
  localparam int TICK_CYC_DEF = MS_NS * CLK_MHZ / 1000;
  localparam int MS_PER_S_DEF = 1000;
  localparam logic [DW-1:0] SELFCHK_S = 16'h0003;
  localparam logic [DW-1:0] PULSE_S = 16'h0001;
  // Trip limits in ms; a fault trips one tick before the limit
  localparam logic [DW-1:0] PHSEQ_MS = 16'h07d0;
  localparam logic [DW-1:0] FAST_MS = 16'h00c8;
  localparam logic [DW-1:0] UNBAL_MS = 16'h1388;
  localparam logic [DW-1:0] TEMP_MS = 16'h07d0;
  localparam int NF = 7;
  localparam int F_PHSEQ = 0;
  localparam int F_ROTOR = 1;
  localparam int F_SHORT = 2;
  localparam int F_LOSS = 3;
  localparam int F_UNBAL = 4;
  localparam int F_OVLD = 5;
  localparam int F_TEMP = 6;
  // Register offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAR = 8'h04;
  localparam logic [7:0] A_LDLY = 8'h08;
  localparam logic [7:0] A_EMPTY = 8'h0c;
  localparam logic [7:0] A_STOP = 8'h10;
  localparam logic [7:0] A_RSTRT = 8'h14;
  localparam logic [7:0] A_LDP = 8'h18;
  localparam logic [7:0] A_ULP = 8'h1c;
  localparam logic [7:0] A_RATED = 8'h20;
  localparam logic [7:0] A_TLIM = 8'h24;
  localparam logic [7:0] A_FANON = 8'h28;
  localparam logic [7:0] A_FANOFF = 8'h2c;
  localparam logic [7:0] A_STAT = 8'h30;
  localparam logic [7:0] A_REMAIN = 8'h34;
  localparam int C_REMOTE = 0;
  localparam int C_MANUAL = 1;
  localparam int C_CLEAR = 2;
  localparam int S_ESTOP = 7;
  localparam int S_STATE = 8;
  // Reset values
  localparam logic [DW-1:0] STAR_RST = 16'h0006;
  localparam logic [DW-1:0] LDLY_RST = 16'h0002;
  localparam logic [DW-1:0] EMPTY_RST = 16'h04b0;
  localparam logic [DW-1:0] STOP_RST = 16'h000a;
  localparam logic [DW-1:0] RSTRT_RST = 16'h005a;
  localparam logic [DW-1:0] LDP_RST = 16'h0258;
  localparam logic [DW-1:0] ULP_RST = 16'h02bc;
  localparam logic [DW-1:0] RATED_RST = 16'h0064;
  localparam logic [DW-1:0] TLIM_RST = 16'h006e;
  localparam logic [DW-1:0] FANON_RST = 16'h0078;
  localparam logic [DW-1:0] FANOFF_RST = 16'h0046;

  typedef enum logic [3:0] {
    ST_SELFCHK, ST_IDLE, ST_STAR, ST_SWITCH, ST_LOADDLY,
    ST_LOADED, ST_UNLOADED, ST_PULSE, ST_STOPDLY, ST_AUTOWAIT
  } csq_state_e;

  typedef struct packed {
    logic [2:0][DW-1:0] main_motor_current_in;
    logic [DW-1:0] fan_current_in;
    logic [DW-1:0] pressure;
    logic [DW-1:0] temperature;
    logic [2:0] phase_present;
    logic phase_order_ok;
  } csq_sense_s;

  typedef struct packed {
    logic main_contactor_out;
    logic star_contactor_out;
    logic delta_contactor_out;
    logic load_valve;
    logic release_valve;
    logic fan;
  } csq_out_s;
endpackage

// file: design/csq_sequencer.sv
// Star-delta start, load/unload control and motor protection of a compressor.
// Sensor values are unsigned and synchronous; buttons are one-cycle or level.
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
module csq_sequencer
  import csq_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF,
  parameter int MS_PER_S = MS_PER_S_DEF
)
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [DW-1:0] rdata_o,
  input wire csq_sense_s sense_i,
  input wire logic on_btn_i,
  input wire logic off_btn_i,
  input wire logic load_btn_i,
  input wire logic unload_btn_i,
  input wire logic remote_start_i,
  input wire logic remote_stop_i,
  input wire logic estop_i,
  output csq_out_s out_o,
  output logic power_indicator_o,
  output logic run_o,
  output logic fault_o,
  output logic [DW-1:0] restart_remain_o
);
  if (TICK_CYC < 2 || MS_PER_S < 1)
  begin : g_bad
    $error("csq_sequencer: tick parameters out of range");
  end

  csq_state_e state, next_state;
  logic [31:0] pre;
  logic [15:0] ms_cnt;
  logic ms_tick, sec_tick;
  logic [DW-1:0] st_sec, lock_s;
  logic [DW-1:0] star_dly, load_dly, empty_dly, stop_dly, rstrt_dly;
  logic [DW-1:0] load_sp, unload_sp, rated, tlim, fan_on_t, fan_off_t;
  logic remote, manual, clr, estop_lat, auto_stop, fan_hot;
  logic [NF-1:0] cond, flt;
  logic [DW-1:0] lim [NF];
  logic fault_any, motor_on, start_req, stop_req, can_start;
  logic [DW-1:0] mx, mn, ovl_lim;
  logic [23:0] c10, d100, m60;
  logic [DW-1:0] press;

  assign press = sense_i.pressure;

  // Millisecond and second time base
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      pre <= '0;
      ms_cnt <= '0;
    end
    else
    begin
      pre <= ms_tick ? '0 : pre + 32'h1;
      if (ms_tick)
        ms_cnt <= sec_tick ? '0 : ms_cnt + 16'h1;
    end
  end
  assign ms_tick = (pre == 32'(TICK_CYC - 1));
  assign sec_tick = ms_tick && (ms_cnt == 16'(MS_PER_S - 1));

  // Register writes
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      remote <= 1'b0;
      manual <= 1'b0;
      star_dly <= STAR_RST;
      load_dly <= LDLY_RST;
      empty_dly <= EMPTY_RST;
      stop_dly <= STOP_RST;
      rstrt_dly <= RSTRT_RST;
      load_sp <= LDP_RST;
      unload_sp <= ULP_RST;
      rated <= RATED_RST;
      tlim <= TLIM_RST;
      fan_on_t <= FANON_RST;
      fan_off_t <= FANOFF_RST;
    end
    else if (we_i)
    begin
      case (addr_i)
        A_CTRL:
        begin
          remote <= wdata_i[C_REMOTE];
          manual <= wdata_i[C_MANUAL];
        end
        A_STAR: star_dly <= wdata_i;
        A_LDLY: load_dly <= wdata_i;
        A_EMPTY: empty_dly <= wdata_i;
        A_STOP: stop_dly <= wdata_i;
        A_RSTRT: rstrt_dly <= wdata_i;
        A_LDP: load_sp <= wdata_i;
        A_ULP: unload_sp <= wdata_i;
        A_RATED: rated <= wdata_i;
        A_TLIM: tlim <= wdata_i;
        A_FANON: fan_on_t <= wdata_i;
        A_FANOFF: fan_off_t <= wdata_i;
        default: ;
      endcase
    end
  end
  assign clr = we_i && addr_i == A_CTRL && wdata_i[C_CLEAR];

  // Register reads, data the cycle after the strobe
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      rdata_o <= '0;
    else if (re_i)
    begin
      case (addr_i)
        A_CTRL: rdata_o <= {14'h0, manual, remote};
        A_STAR: rdata_o <= star_dly;
        A_LDLY: rdata_o <= load_dly;
        A_EMPTY: rdata_o <= empty_dly;
        A_STOP: rdata_o <= stop_dly;
        A_RSTRT: rdata_o <= rstrt_dly;
        A_LDP: rdata_o <= load_sp;
        A_ULP: rdata_o <= unload_sp;
        A_RATED: rdata_o <= rated;
        A_TLIM: rdata_o <= tlim;
        A_FANON: rdata_o <= fan_on_t;
        A_FANOFF: rdata_o <= fan_off_t;
        A_STAT: rdata_o <= {4'h0, state, estop_lat, flt};
        A_REMAIN: rdata_o <= lock_s;
        default: rdata_o <= '0;
      endcase
    end
    else
      rdata_o <= '0;
  end

  // Phase current extremes
  always_comb
  begin
    mx = sense_i.main_motor_current_in[0];
    mn = sense_i.main_motor_current_in[0];
    for (int i = 1; i < 3; i++)
    begin
      if (sense_i.main_motor_current_in[i] > mx)
        mx = sense_i.main_motor_current_in[i];
      if (sense_i.main_motor_current_in[i] < mn)
        mn = sense_i.main_motor_current_in[i];
    end
  end
  assign c10 = 24'(mx) * 24'h00000a;
  assign d100 = 24'(mx - mn) * 24'h000064;
  assign m60 = 24'(mx) * 24'h00003c;

  // Inverse-time overload delay in ms by current multiple
  always_comb
  begin
    if (c10 >= 24'(rated) * 24'h00001e)
      ovl_lim = 16'h03e8;
    else if (c10 >= 24'(rated) * 24'h000014)
      ovl_lim = 16'h1388;
    else if (c10 >= 24'(rated) * 24'h000010)
      ovl_lim = 16'h1f40;
    else if (c10 >= 24'(rated) * 24'h00000f)
      ovl_lim = 16'h5dc0;
    else if (c10 >= 24'(rated) * 24'h00000d)
      ovl_lim = 16'hbb80;
    else
      ovl_lim = 16'hea60;
  end

  assign motor_on = state inside {ST_STAR, ST_SWITCH, ST_LOADDLY, ST_LOADED,
                                  ST_UNLOADED, ST_PULSE, ST_STOPDLY};
  assign cond[F_PHSEQ] = !sense_i.phase_order_ok;
  assign cond[F_ROTOR] = motor_on && c10 >= 24'(rated) * 24'h000028;
  assign cond[F_SHORT] = motor_on && c10 >= 24'(rated) * 24'h000050;
  assign cond[F_LOSS] = motor_on && sense_i.phase_present != 3'h7;
  assign cond[F_UNBAL] = motor_on && mx != '0 && d100 >= m60;
  assign cond[F_OVLD] = motor_on && c10 >= 24'(rated) * 24'h00000c;
  assign cond[F_TEMP] = sense_i.temperature > tlim;
  assign lim[F_PHSEQ] = PHSEQ_MS;
  assign lim[F_ROTOR] = FAST_MS;
  assign lim[F_SHORT] = FAST_MS;
  assign lim[F_LOSS] = FAST_MS;
  assign lim[F_UNBAL] = UNBAL_MS;
  assign lim[F_OVLD] = ovl_lim;
  assign lim[F_TEMP] = TEMP_MS;

  // Each fault must persist for one ms tick less than its limit; latched until cleared
  for (genvar f = 0; f < NF; f++)
  begin : g_flt
    logic [DW-1:0] cnt;
    always_ff @(posedge ref_clk_i)
    begin
      if (!rstn_i)
        cnt <= '0;
      else if (!cond[f])
        cnt <= '0;
      else if (ms_tick && cnt != 16'hffff)
        cnt <= cnt + 16'h1;
    end
    always_ff @(posedge ref_clk_i)
    begin
      if (!rstn_i)
        flt[f] <= 1'b0;
      else if (cond[f] && cnt + 16'h1 >= lim[f])
        flt[f] <= 1'b1; // Set wins over clear
      else if (clr && !cond[f])
        flt[f] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      estop_lat <= 1'b0;
    else if (estop_i)
      estop_lat <= 1'b1;
    else if (clr)
      estop_lat <= 1'b0;
  end

  assign fault_any = |flt || estop_lat || estop_i;
  assign start_req = remote ? remote_start_i : on_btn_i;
  assign stop_req = remote ? remote_stop_i : off_btn_i;
  assign can_start = lock_s == '0 && !fault_any;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_SELFCHK:
        if (st_sec >= SELFCHK_S)
          next_state = ST_IDLE;
      ST_IDLE:
        if (start_req && can_start)
          next_state = ST_STAR;
      ST_STAR:
        if (st_sec >= star_dly)
          next_state = ST_SWITCH;
      ST_SWITCH:
        next_state = ST_LOADDLY;
      ST_LOADDLY:
        if (st_sec >= load_dly)
          next_state = manual ? ST_UNLOADED : ST_LOADED;
      ST_LOADED:
        if (press > unload_sp)
          next_state = ST_UNLOADED;
        else if (unload_btn_i && press > load_sp)
          next_state = ST_UNLOADED;
      ST_UNLOADED:
        if (!manual && press < load_sp)
          next_state = ST_LOADED;
        else if (load_btn_i)
          next_state = press > unload_sp ? ST_PULSE : ST_LOADED;
        else if (st_sec >= empty_dly)
          next_state = ST_STOPDLY;
      ST_PULSE:
        if (st_sec >= PULSE_S)
          next_state = ST_UNLOADED;
      ST_STOPDLY:
        if (st_sec >= stop_dly)
          next_state = auto_stop ? ST_AUTOWAIT : ST_IDLE;
      ST_AUTOWAIT:
        if (press <= load_sp && can_start)
          next_state = ST_STAR;
      default:
        next_state = ST_IDLE;
    endcase
    if (state != ST_SELFCHK)
    begin
      if (fault_any && state != ST_IDLE)
        next_state = ST_IDLE;
      else if (stop_req && (state == ST_STAR || state == ST_SWITCH
                            || state == ST_AUTOWAIT))
        next_state = ST_IDLE;
      else if (stop_req && motor_on)
        next_state = ST_STOPDLY;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      state <= ST_SELFCHK;
      st_sec <= '0;
    end
    else
    begin
      state <= next_state;
      if (next_state != state)
        st_sec <= '0;
      else if (sec_tick && st_sec != 16'hffff)
        st_sec <= st_sec + 16'h1;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      auto_stop <= 1'b0;
    else if (state == ST_UNLOADED && next_state == ST_STOPDLY && !stop_req)
      auto_stop <= 1'b1;
    else if (stop_req || fault_any)
      auto_stop <= 1'b0;
  end

  // Restart lockout, loaded whenever the motor stops or the emergency stop input is high
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      lock_s <= '0;
    else if ((motor_on && !(next_state inside {ST_STAR, ST_SWITCH, ST_LOADDLY,
             ST_LOADED, ST_UNLOADED, ST_PULSE, ST_STOPDLY})) || estop_i)
      lock_s <= rstrt_dly;
    else if (sec_tick && lock_s != '0)
      lock_s <= lock_s - 16'h1;
  end

  // Hysteresis keeps the fan from chattering near one threshold
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      fan_hot <= 1'b0;
    else if (sense_i.temperature > fan_on_t)
      fan_hot <= 1'b1;
    else if (sense_i.temperature < fan_off_t)
      fan_hot <= 1'b0;
  end

  // Outputs follow state one cycle later; star and delta never share a state
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      out_o <= '0;
      run_o <= 1'b0;
      fault_o <= 1'b0;
      power_indicator_o <= 1'b0;
      restart_remain_o <= '0;
    end
    else
    begin
      out_o.main_contactor_out <= motor_on;
      out_o.star_contactor_out <= state == ST_STAR;
      out_o.delta_contactor_out <= motor_on && state != ST_STAR
                                   && state != ST_SWITCH;
      out_o.load_valve <= state == ST_LOADED || state == ST_PULSE;
      out_o.release_valve <= state == ST_UNLOADED || state == ST_STOPDLY;
      out_o.fan <= motor_on && fan_hot;
      run_o <= motor_on;
      fault_o <= fault_any;
      power_indicator_o <= 1'b1;
      restart_remain_o <= lock_s;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_star_delta;
    !(out_o.star_contactor_out && out_o.delta_contactor_out);
  endproperty
  a_star_delta: assert property (p_star_delta) else $error("star and delta on");

  property p_no_load_start;
    (state == ST_STAR || state == ST_SWITCH) |=> ##1 !out_o.load_valve;
  endproperty
  a_no_load_start: assert property (p_no_load_start) else $error("load in start");

  property p_selfchk;
    state == ST_SELFCHK |=> state inside {ST_SELFCHK, ST_IDLE};
  endproperty
  a_selfchk: assert property (p_selfchk) else $error("start during self-check");

  property p_unload;
    state == ST_LOADED && press > unload_sp |=> state != ST_LOADED
      ##1 !out_o.load_valve;
  endproperty
  a_unload: assert property (p_unload) else $error("no unload above setpoint");

  property p_lockout;
    state == ST_IDLE && lock_s != '0 |=> state != ST_STAR;
  endproperty
  a_lockout: assert property (p_lockout) else $error("restart during lockout");

  property p_fault_stop;
    fault_any && motor_on |=> state == ST_IDLE ##1 !out_o.main_contactor_out;
  endproperty
  a_fault_stop: assert property (p_fault_stop) else $error("fault did not stop");

  property p_stop_valves;
    state == ST_STOPDLY |=> out_o.release_valve && !out_o.load_valve;
  endproperty
  a_stop_valves: assert property (p_stop_valves) else $error("stop delay valves");

  property p_fan;
    sense_i.temperature > fan_on_t && motor_on ##1 motor_on |=> out_o.fan;
  endproperty
  a_fan: assert property (p_fan) else $error("fan not on when hot");

  c_start: cover property (state == ST_LOADDLY ##1 state == ST_LOADED);
  c_idle_stop: cover property (state == ST_STOPDLY ##1 state == ST_AUTOWAIT);
  c_trip: cover property ($rose(fault_o) && run_o);
endmodule

// file: bench/csq_plant.sv
// Plant model: motor currents, line pressure, temperature and supply phases.
// Assumes the sequencer's registered outputs; the bench sets the conditions.
`timescale 1ns/1ns
module csq_plant import csq_pkg::*;
(
  input wire logic ref_clk_i,
  input wire csq_out_s out_i,
  input wire logic [DW-1:0] rated_i,
  input wire logic [7:0] mult_x10_i,
  input wire logic [2:0] phase_i,
  input wire logic order_ok_i,
  input wire logic [DW-1:0] press_i,
  input wire logic [DW-1:0] temp_i,
  output csq_sense_s sense_o
);
  logic [DW-1:0] amps;

  // Current flows only with the main contactor closed
  always_ff @(posedge ref_clk_i)
  begin
    amps <= out_i.main_contactor_out ? DW'(32'(rated_i) * mult_x10_i / 10) : '0;
  end

  // A missing phase carries no current
  always_comb
  begin
    sense_o.main_motor_current_in[0] = phase_i[0] ? amps : '0;
    sense_o.main_motor_current_in[1] = phase_i[1] ? amps : '0;
    sense_o.main_motor_current_in[2] = phase_i[2] ? amps : '0;
    sense_o.fan_current_in = out_i.fan ? 16'h000a : 16'h0000;
    sense_o.pressure = press_i;
    sense_o.temperature = temp_i;
    sense_o.phase_present = phase_i;
    sense_o.phase_order_ok = order_ok_i;
  end
endmodule

// file: bench/testbench.sv
// Self-checking bench for the compressor motor sequencer and its plant model.
// Assumes a shortened time base: 10 cycles a millisecond, 4 ms a second.
`timescale 1ns/1ns
module testbench import csq_pkg::*;
;
  localparam int TK = 10;
  localparam int MS = 4;
  localparam int SEC = TK * MS;
  localparam int MAIN = 5, STAR = 4, DELTA = 3, LOAD = 2, REL = 1, FAN = 0, RUN = 6, FLT = 7;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [DW-1:0] wdata = 16'h0000;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [DW-1:0] rdata;
  logic [5:0] btn = 6'h00;
  logic estop = 1'b0;
  logic [7:0] mult = 8'h0a;
  logic [2:0] ph = 3'h7;
  logic ord_ok = 1'b1;
  logic [DW-1:0] press = 16'h024e;
  logic [DW-1:0] temp = 16'h0019;
  csq_sense_s sense;
  csq_out_s outs;
  logic power_indicator;
  logic run;
  logic flt;
  logic [DW-1:0] remain;
  wire logic [7:0] obs = {flt, run, outs};
  int err_total = 0;
  int checks = 0;
  int took;
  logic [DW-1:0] d;
  logic [7:0] ra[12] = '{A_STAR, A_LDLY, A_EMPTY, A_STOP, A_RSTRT, A_LDP, A_ULP, A_RATED,
    A_TLIM, A_FANON, A_FANOFF, 8'h3c};
  logic [DW-1:0] rv[12] = '{STAR_RST, LDLY_RST, EMPTY_RST, STOP_RST, RSTRT_RST, LDP_RST,
    ULP_RST, RATED_RST, TLIM_RST, FANON_RST, FANOFF_RST, 16'h0000};
  // Trip limits count real milliseconds, not the shortened second
  int lim[5] = '{20010, 2010, 2010, 20010, 1001 * TK};
  int sb[5] = '{0, 2, 3, 6, 5};

  always #5 ref_clk_i = ~ref_clk_i;

  csq_plant plant (.ref_clk_i(ref_clk_i), .out_i(outs), .rated_i(RATED_RST),
    .mult_x10_i(mult), .phase_i(ph), .order_ok_i(ord_ok), .press_i(press),
    .temp_i(temp), .sense_o(sense));

  csq_sequencer #(.TICK_CYC(TK), .MS_PER_S(MS)) DUT (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata), .we_i(we),
    .re_i(re), .rdata_o(rdata), .sense_i(sense), .on_btn_i(btn[0]), .off_btn_i(btn[1]),
    .load_btn_i(btn[2]), .unload_btn_i(btn[3]), .remote_start_i(btn[4]),
    .remote_stop_i(btn[5]), .estop_i(estop), .out_o(outs), .power_indicator_o(power_indicator),
    .run_o(run), .fault_o(flt), .restart_remain_o(remain));

  task automatic chk(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [DW-1:0] v);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= v;
    we <= 1'b1;
    @(posedge ref_clk_i);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [DW-1:0] v);
    @(posedge ref_clk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge ref_clk_i);
    re <= 1'b0;
    #1 v = rdata;
  endtask

  // Buttons: 0 on, 1 off, 2 load, 3 unload, 4 remote start, 5 remote stop
  task automatic pulse(input int k);
    @(posedge ref_clk_i);
    btn <= 6'h01 << k;
    @(posedge ref_clk_i);
    btn <= 6'h00;
  endtask

  // Bounded wait for one observed output bit, then compare it
  task automatic wt(input int b, input logic v, input int n);
    #1 took = 0;
    while (obs[b] !== v && took < n)
    begin
      @(posedge ref_clk_i);
      #1 took++;
    end
    chk($sformatf("output bit %0d", b), {15'h0, v}, {15'h0, obs[b]});
  endtask

  task automatic fault_set(input int k, input logic on);
    @(posedge ref_clk_i);
    case (k)
      0: ord_ok <= ~on;
      1: mult <= on ? 8'h50 : 8'h0a;
      2: ph <= on ? 3'h6 : 3'h7;
      3: temp <= on ? 16'h0096 : 16'h0019;
      default: mult <= on ? 8'h1e : 8'h0a;
    endcase
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Star must never overlap delta or the load valve
  always @(posedge ref_clk_i)
    if (rstn_i && outs.star_contactor_out && (outs.delta_contactor_out || outs.load_valve))
    begin
      err_total++;
      $display("unexpected star overlap: expected 0 seen 1");
    end

  initial
  begin
    cyc(90000);
    err_total++;
    $display("watchdog expired");
    results();
  end

  initial
  begin
    cyc(10);
    chk("outputs in reset", 16'h0, obs);
    rstn_i <= 1'b1;
    cyc(3);
    chk("power indicator", 16'h1, power_indicator);
    for (int i = 0; i < 12; i++)
    begin
      rd(ra[i], d);
      chk($sformatf("reg %h", ra[i]), rv[i], d);
    end
    wr(A_STAT, 16'hffff);
    pulse(0);
    cyc(4);
    chk("main in selfcheck", 16'h0, outs.main_contactor_out);
    rd(A_STAT, d);
    chk("state in selfcheck", 16'h0, d[11:8]);
    cyc(3 * SEC + 8);
    rd(A_STAT, d);
    chk("state after selfcheck", 16'h1, d[11:8]);
    $display("test selfcheck done");
    wr(A_STAR, 16'h0002);
    wr(A_LDLY, 16'h0001);
    wr(A_EMPTY, 16'h0002);
    wr(A_STOP, 16'h0001);
    wr(A_RSTRT, 16'h0002);
    pulse(0);
    wt(MAIN, 1'b1, 4);
    chk("star", 16'h1, obs[STAR]);
    wt(STAR, 1'b0, 3 * SEC);
    chk("star time", 16'h1, took > SEC);
    chk("delta gap", 16'h0, obs[DELTA]);
    wt(DELTA, 1'b1, 2);
    chk("load in start", 16'h0, obs[LOAD]);
    wt(LOAD, 1'b1, 2 * SEC + 4);
    $display("test start done");
    @(posedge ref_clk_i) press <= 16'h02bd;
    wt(LOAD, 1'b0, 4);
    chk("release", 16'h1, obs[REL]);
    @(posedge ref_clk_i) press <= 16'h0257;
    wt(LOAD, 1'b1, 4);
    chk("release", 16'h0, obs[REL]);
    @(posedge ref_clk_i) press <= 16'h0226;
    pulse(3);
    cyc(4);
    chk("unload below setpoint", 16'h1, obs[LOAD]);
    @(posedge ref_clk_i) press <= 16'h028a;
    pulse(3);
    wt(LOAD, 1'b0, 4);
    @(posedge ref_clk_i) press <= 16'h024e;
    wt(LOAD, 1'b1, 4);
    $display("test load control done");
    @(posedge ref_clk_i) press <= 16'h02c6;
    wt(LOAD, 1'b0, 4);
    pulse(2);
    wt(LOAD, 1'b1, 4);
    wt(LOAD, 1'b0, 2 * SEC + 4);
    @(posedge ref_clk_i) press <= 16'h028a;
    pulse(2);
    wt(LOAD, 1'b1, 4);
    cyc(SEC + SEC / 2);
    chk("manual hold", 16'h1, obs[LOAD]);
    @(posedge ref_clk_i) press <= 16'h02c6;
    wt(LOAD, 1'b0, 4);
    wt(MAIN, 1'b0, 5 * SEC);
    @(posedge ref_clk_i) press <= 16'h028a;
    cyc(4 * SEC);
    chk("auto restart early", 16'h0, obs[MAIN]);
    @(posedge ref_clk_i) press <= 16'h024e;
    wt(MAIN, 1'b1, 8);
    $display("test manual and idle stop done");
    for (int k = 0; k < 5; k++)
    begin
      if (run !== 1'b1)
      begin
        pulse(0);
      end
      wt(DELTA, 1'b1, 4 * SEC);
      fault_set(k, 1'b1);
      wt(FLT, 1'b1, lim[k]);
      if (k == 4)
        chk("overload delay", 16'h1, took > 990 * TK);
      // Run and main drop one cycle after the fault output rises
      wt(RUN, 1'b0, 2);
      chk("main after trip", 16'h0, obs[MAIN]);
      rd(A_STAT, d);
      if (sb[k] >= 0)
        chk("fault latch", 16'h1, d[sb[k]]);
      fault_set(k, 1'b0);
      cyc(3 * SEC);
      pulse(0);
      cyc(4);
      chk("start with fault latched", 16'h0, obs[MAIN]);
      wr(A_CTRL, 16'h0004);
      pulse(0);
      wt(MAIN, 1'b1, 8);
    end
    $display("test protection done");
    wt(DELTA, 1'b1, 4 * SEC);
    @(posedge ref_clk_i) estop <= 1'b1;
    wt(RUN, 1'b0, 4);
    chk("estop fault", 16'h1, flt);
    @(posedge ref_clk_i) estop <= 1'b0;
    cyc(3 * SEC);
    pulse(0);
    cyc(4);
    chk("start before clear", 16'h0, obs[MAIN]);
    wr(A_CTRL, 16'h0004);
    pulse(0);
    wt(MAIN, 1'b1, 8);
    wt(DELTA, 1'b1, 4 * SEC);
    @(posedge ref_clk_i) temp <= 16'h0079;
    wt(FAN, 1'b1, 8);
    @(posedge ref_clk_i) temp <= 16'h0064;
    cyc(8);
    chk("fan hysteresis", 16'h1, obs[FAN]);
    @(posedge ref_clk_i) temp <= 16'h0045;
    wt(FAN, 1'b0, 8);
    $display("test estop and fan done");
    wt(LOAD, 1'b1, 2 * SEC + 4);
    pulse(1);
    wt(LOAD, 1'b0, 4);
    chk("release on stop", 16'h1, obs[REL]);
    chk("main in stop delay", 16'h1, obs[MAIN]);
    wt(MAIN, 1'b0, 2 * SEC + 4);
    cyc(2);
    chk("remain shown", 16'h1, remain != 16'h0);
    pulse(0);
    cyc(4);
    chk("start in lockout", 16'h0, obs[MAIN]);
    cyc(3 * SEC);
    chk("remain expired", 16'h0, remain);
    $display("test stop done");
    wr(A_CTRL, 16'h0002);
    pulse(0);
    wt(DELTA, 1'b1, 4 * SEC);
    cyc(SEC);
    chk("manual mode unloaded", 16'h0, obs[LOAD]);
    pulse(2);
    wt(LOAD, 1'b1, 4);
    wr(A_CTRL, 16'h0003);
    pulse(1);
    cyc(3 * SEC);
    chk("local stop in remote", 16'h1, obs[MAIN]);
    pulse(5);
    wt(MAIN, 1'b0, 2 * SEC + 4);
    cyc(3 * SEC);
    pulse(0);
    cyc(4);
    chk("local start in remote", 16'h0, obs[MAIN]);
    pulse(4);
    wt(MAIN, 1'b1, 8);
    $display("test modes done");
    results();
  end
endmodule
